// *** dv/ipo_led_model.sv ***
// Purpose: Far-side model of the indicator pins and the status sources.
// Assumes: One clock; all signals are levels.
// Notes:   Samples the pins once per edge, as a lamp or a probe would.
`timescale 1ns/1ps
`default_nettype none
module ipo_led_model (
  input  wire logic           ref_clk,
  input  wire logic [2:0]     led_pin_out,
  input  wire logic [2:0]     func_cmd,
  input  wire logic [5:0]     compl_cmd,
  output var  logic [2:0]     led_func_in,
  output var  ipo_pkg::ipo_compl_s compl_status,
  output var  logic [2:0]     lit
);
  import ipo_pkg::*;
  always @(posedge ref_clk) begin
    led_func_in  <= func_cmd;
    compl_status <= ipo_compl_s'(compl_cmd);
    lit          <= led_pin_out;
  end
endmodule // ipo_led_model
`default_nettype wire

// *** dv/tb.sv ***
// Purpose: Self-checking bench for the indicator pin override block.
// Assumes: Every bus wait is bounded; no fixed answer time is assumed.
// Notes:   Pin levels are seen through the far-side model, one edge late.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ipo_pkg::*;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [12:0] address = 13'h0;
  logic [31:0] writedata = 32'h0;
  logic [3:0]  byteenable = 4'hf;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [2:0]  led_func_in;
  ipo_compl_s  compl_status;
  logic [2:0]  led_pin_out;
  logic [2:0]  func_cmd = 3'h0;
  logic [5:0]  compl_cmd = 6'h0;
  logic [2:0]  lit;
  int          num_errors = 0;
  int          n_compared = 0;
  localparam logic [15:0] FRC_CFG [5] = '{16'h0092, 16'h01b6, 16'h0124, 16'h0049, 16'h01ff};
  localparam logic [2:0]  FRC_FN  [5] = '{3'h5, 3'h0, 3'h7, 3'h3, 3'h5};
  localparam logic [2:0]  FRC_EXP [5] = '{3'h5, 3'h7, 3'h0, 3'h4, 3'h0};

  always #25 ref_clk = ~ref_clk;

  ipo_indicator_override dut (.ref_clk(ref_clk), .srst(srst), .address(address),
    .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .led_func_in(led_func_in),
    .compl_status(compl_status), .led_pin_out(led_pin_out));
  ipo_led_model partner (.ref_clk(ref_clk), .led_pin_out(led_pin_out),
    .func_cmd(func_cmd), .compl_cmd(compl_cmd), .led_func_in(led_func_in),
    .compl_status(compl_status), .lit(lit));

  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // The request stays up until waitrequest is seen low at a rising edge, then drops there.
  task automatic bus(input logic is_wr, input logic [10:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    rd = 32'h0;
    @(posedge ref_clk);
    read      <= !is_wr;
    write     <= is_wr;
    address   <= {idx, 2'b00};
    writedata <= wd;
    for (n = 0; n < 16; n++) begin
      @(posedge ref_clk);
      if (waitrequest === 1'b0) break;
    end
    if (n == 16) begin
      num_errors++;
      conclude();
    end else begin
      rd = readdata;
      read  <= 1'b0;
      write <= 1'b0;
    end
  endtask

  task automatic wr(input logic [10:0] idx, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, idx, d, r);
  endtask

  task automatic rdc(input logic [10:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, idx, 32'h0, r);
    chk("readdata", r, exp);
  endtask

  task automatic pins(input logic [2:0] exp);
    repeat (4) @(posedge ref_clk);
    chk("pins", {29'h0, lit}, {29'h0, exp});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge ref_clk);
    srst <= 1'b0;
    rdc(IDX_DRIVE_CFG, 32'h0);
    rdc(IDX_FUNC_SEL, 32'h0);
    rdc(11'h453, 32'h0);
    pins(3'h0);
    wr(IDX_DRIVE_CFG, 32'hffff);
    rdc(IDX_DRIVE_CFG, 32'h0fff);
    byteenable <= 4'h2;
    wr(IDX_DRIVE_CFG, 32'h0);
    byteenable <= 4'hf;
    rdc(IDX_DRIVE_CFG, 32'h00ff);
    $display("test reset_and_map done");
    for (int i = 0; i < 5; i++) begin
      func_cmd <= FRC_FN[i];
      wr(IDX_DRIVE_CFG, {16'h0, FRC_CFG[i]});
      pins(FRC_EXP[i]);
    end
    $display("test force_and_polarity done");
    wr(IDX_FUNC_SEL, 32'hffff);
    rdc(IDX_FUNC_SEL, 32'h0707);
    wr(IDX_FUNC_SEL, {29'h0, FSEL_OBSERVE});
    for (int s = 0; s < 8; s++) begin
      func_cmd  <= 3'h0;
      compl_cmd <= 6'(1 << s);
      wr(IDX_DRIVE_CFG, 32'(s << COMPL_SEL_LSB));
      pins({2'h0, 1'(s < 6)});
      func_cmd  <= 3'h1;
      compl_cmd <= ~6'(1 << s);
      pins(3'h0);
    end
    compl_cmd <= 6'h01;
    wr(IDX_DRIVE_CFG, 32'h1);
    pins(3'h0);
    compl_cmd <= 6'h00;
    pins(3'h1);
    wr(IDX_DRIVE_CFG, 32'h0);
    wr(IDX_FUNC_SEL, 32'h4);
    pins(3'h1);
    $display("test compliance_observe done");
    conclude();
  end
endmodule // tb
`default_nettype wire

// *** verilog/ipo_indicator_override.sv ***
// Purpose: Register-controlled override of the three indicator output pins.
// Assumes: All inputs synchronous to ref_clk; Avalon-MM slave with waitrequest.
// Notes:   Each access is answered on the second cycle of its request.
// How it works
// - Pin 0 select 5 routes chosen compliance status.
// - Pin 2 force-enable bit 8 drives bit 7.
// - Pin 1 force-enable bit 5 drives bit 4.
// - Pin 0 force-enable bit 2 drives bit 1.
// - Force value ignored unless enable set.
// - Override register at 0x451, resets to zero.
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module ipo_indicator_override
  import ipo_pkg::*;
#(
  parameter int unsigned PINS = ipo_pkg::NUM_PINS
) (
  input  wire logic                       ref_clk,
  input  wire logic                       srst,
  input  wire logic [ipo_pkg::ADDR_W-1:0] address,
  input  wire logic                       read,
  input  wire logic                       write,
  input  wire logic [ipo_pkg::DATA_W-1:0] writedata,
  input  wire logic [3:0]                 byteenable,
  output logic      [ipo_pkg::DATA_W-1:0] readdata,
  output logic                            waitrequest,
  input  wire logic [PINS-1:0]            led_func_in,
  input  wire ipo_pkg::ipo_compl_s        compl_status,
  output logic      [PINS-1:0]            led_pin_out
);
  import ipo_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave.

  ipo_bus_e                   bus_q;
  ipo_bus_e                   bus_d;
  logic     [REG_W-1:0]       drive_q;
  logic     [REG_W-1:0]       drive_d;
  logic     [REG_W-1:0]       fsel_q;
  logic     [REG_W-1:0]       fsel_d;
  logic     [DATA_W-1:0]      rdata_q;
  logic     [DATA_W-1:0]      rdata_d;
  logic     [REG_W-1:0]       wmask;
  logic                       req;
  logic                       hit_drive;
  logic                       hit_fsel;
  logic                       done;

  assign req       = read | write;
  assign hit_drive = (address[ADDR_W-1:2] == IDX_DRIVE_CFG);
  assign hit_fsel  = (address[ADDR_W-1:2] == IDX_FUNC_SEL);
  // The answer lands in the second cycle, giving the read mux a full cycle.
  assign done        = req && (bus_q == IPO_BUS_ACK);
  assign waitrequest = req && (bus_q == IPO_BUS_IDLE);
  assign readdata    = rdata_q;
  assign wmask       = {{8{byteenable[1]}}, {8{byteenable[0]}}};

  always_comb begin
    bus_d   = bus_q;
    drive_d = drive_q;
    fsel_d  = fsel_q;
    rdata_d = rdata_q;
    unique case (bus_q)
      IPO_BUS_IDLE: begin
        if (req) begin
          bus_d = IPO_BUS_ACK;
          rdata_d = '0;
          if (read && hit_drive) begin
            rdata_d = {16'h0000, drive_q};
          end else if (read && hit_fsel) begin
            rdata_d = {16'h0000, fsel_q};
          end
        end
      end
      IPO_BUS_ACK: begin
        bus_d = IPO_BUS_IDLE;
        if (done && write && hit_drive) begin
          drive_d = (drive_q & ~(wmask & DRIVE_CFG_WMASK)) |
                    (writedata[REG_W-1:0] & wmask & DRIVE_CFG_WMASK);
        end
        if (done && write && hit_fsel) begin
          fsel_d = (fsel_q & ~(wmask & FUNC_SEL_WMASK)) |
                   (writedata[REG_W-1:0] & wmask & FUNC_SEL_WMASK);
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bus_q   <= IPO_BUS_IDLE;
      drive_q <= DRIVE_CFG_RST;
      fsel_q  <= FUNC_SEL_RST;
      rdata_q <= '0;
    end else begin
      bus_q   <= bus_d;
      drive_q <= drive_d;
      fsel_q  <= fsel_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin path: normal function, then force, then polarity.

  logic      [PINS-1:0]        normal;
  wire logic [PINS-1:0]        forced_en;
  wire logic [PINS-1:0]        forced_val;
  wire logic [PINS-1:0]        polarity;
  wire logic [PINS-1:0]        pin_q;
  logic      [COMPL_SEL_W-1:0] compl_sel;
  logic                        compl_bit;
  logic      [FSEL_W-1:0]      fsel0;

  assign compl_sel = drive_q[COMPL_SEL_LSB +: COMPL_SEL_W];
  assign fsel0     = fsel_q[FSEL0_LSB +: FSEL_W];

  always_comb begin
    unique case (ipo_compl_sel_e'(compl_sel))
      IPO_CS_LOC_RCVR:  compl_bit = compl_status.loc_rcvr_ok;
      IPO_CS_REM_RCVR:  compl_bit = compl_status.rem_rcvr_ok;
      IPO_CS_LOC_SNR:   compl_bit = compl_status.loc_snr_margin;
      IPO_CS_REM_READY: compl_bit = compl_status.rem_phy_ready;
      IPO_CS_PMA_WDOG:  compl_bit = compl_status.pma_watchdog;
      IPO_CS_LINK_SYNC: compl_bit = compl_status.link_sync;
      // Codes 6 and 7 select nothing, so the pin rests low before polarity.
      default:          compl_bit = 1'b0;
    endcase
  end

  always_comb begin
    normal = led_func_in;
    if (fsel0 == FSEL_OBSERVE) begin
      normal[0] = compl_bit;
    end
  end

  // Each pin owns three adjacent bits: polarity, force value, force enable.
  for (genvar g = 0; g < PINS; g++) begin : g_pin
    assign forced_en[g]  = drive_q[PIN_FIELD_W*g + EN_OFS];
    assign forced_val[g] = drive_q[PIN_FIELD_W*g + VAL_OFS];
    assign polarity[g]   = drive_q[PIN_FIELD_W*g + POL_OFS];
    ipo_pin_slice u_pin (
      .ref_clk    (ref_clk),
      .srst       (srst),
      .normal_lvl (normal[g]),
      .force_en   (forced_en[g]),
      .force_val  (forced_val[g]),
      .invert     (polarity[g]),
      .pin_q      (pin_q[g])
    );
  end

  assign led_pin_out = pin_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  AST_OBSERVE_LINK_SYNC: assert property (
    (fsel_q[2:0] == 3'h5 && drive_q[11:9] == 3'h5 && !drive_q[2] && !drive_q[0])
      |=> (led_pin_out[0] == $past(compl_status.link_sync)))
    else $error("pin 0 does not follow selected link sync status");

  AST_OBSERVE_LOC_RCVR: assert property (
    (fsel_q[2:0] == 3'h5 && drive_q[11:9] == 3'h0 && !drive_q[2] && drive_q[0])
      |=> (led_pin_out[0] == !$past(compl_status.loc_rcvr_ok)))
    else $error("pin 0 does not follow inverted local receiver status");

  AST_FORCE_PIN2: assert property (
    drive_q[8] |=> (led_pin_out[2] == ($past(drive_q[7]) ^ $past(drive_q[6]))))
    else $error("pin 2 not driven by its force value");

  AST_FORCE_PIN1: assert property (
    (drive_q[5] && !drive_q[3]) ##1 (drive_q[5] && !drive_q[3])
      |-> (led_pin_out[1] == $past(drive_q[4])))
    else $error("pin 1 not driven by its force value");

  AST_FORCE_PIN0: assert property (
    (drive_q[2] && !drive_q[0]) |=> (led_pin_out[0] == $past(drive_q[1])))
    else $error("pin 0 not driven by its force value");

  AST_NO_FORCE_PIN1: assert property (
    (!drive_q[5] && !drive_q[3]) |=> (led_pin_out[1] == $past(led_func_in[1])))
    else $error("pin 1 affected by force value while not enabled");

  AST_RESET_ZERO: assert property (
    disable iff (1'b0) $past(srst) |-> (drive_q == 16'h0000 && led_pin_out == 3'h0))
    else $error("override register or pins not zero after reset");

  AST_POLARITY_PIN2: assert property (
    (!drive_q[8] && drive_q[6]) |=> (led_pin_out[2] == !$past(led_func_in[2])))
    else $error("pin 2 polarity not applied");

  AST_WRITE_LANDS: assert property (
    (write && !waitrequest && address == 13'h1144 && byteenable == 4'hf)
      |=> (drive_q == ($past(writedata[15:0]) & 16'h0fff)))
    else $error("write to override register did not land");

  // Bus side: a held request sees exactly one wait cycle, then a clean restart.
  AST_ONE_WAIT: assert property (
    ((read || write) && waitrequest) |=> !waitrequest)
    else $error("request not answered after one wait cycle");

  AST_BACK_TO_IDLE: assert property (
    ((read || write) && !waitrequest) |=> (!(read || write) || waitrequest))
    else $error("request after an answer did not wait again");

  AST_READ_UPPER_ZERO: assert property (
    (read && !waitrequest) |-> (readdata[31:16] == 16'h0000))
    else $error("upper half of read data not zero");

  AST_UNMAPPED_READ: assert property (
    (read && !waitrequest && address[12:2] != 11'h451 && address[12:2] != 11'h452)
      |-> (readdata == 32'h00000000))
    else $error("unmapped read returned nonzero data");

  AST_READ_DRIVE: assert property (
    (read && !waitrequest && address[12:2] == 11'h451) |-> (readdata[15:0] == drive_q))
    else $error("override register read back wrong");

  AST_RESERVED_ZERO: assert property (
    (drive_q[15:12] == 4'h0) && (fsel_q[15:11] == 5'h00) && (fsel_q[7:3] == 5'h00))
    else $error("reserved register bits not zero");

  // Pin side: each pin follows force, normal function and polarity.
  AST_NO_FORCE_PIN0: assert property (
    (!drive_q[2] && !drive_q[0] && fsel_q[2:0] != 3'h5)
      |=> (led_pin_out[0] == $past(led_func_in[0])))
    else $error("pin 0 affected by force value while not enabled");

  AST_NO_FORCE_PIN2: assert property (
    (!drive_q[8] && !drive_q[6]) |=> (led_pin_out[2] == $past(led_func_in[2])))
    else $error("pin 2 affected by force value while not enabled");

  AST_POLARITY_PIN1: assert property (
    (drive_q[5] && drive_q[3]) |=> (led_pin_out[1] == !$past(drive_q[4])))
    else $error("pin 1 polarity not applied to forced value");

  AST_POLARITY_PIN0: assert property (
    (!drive_q[2] && drive_q[0] && fsel_q[2:0] != 3'h5)
      |=> (led_pin_out[0] == !$past(led_func_in[0])))
    else $error("pin 0 polarity not applied");

  AST_OBSERVE_UNUSED_CODE: assert property (
    (fsel_q[2:0] == 3'h5 && drive_q[11:10] == 2'h3 && !drive_q[2] && !drive_q[0])
      |=> !led_pin_out[0])
    else $error("pin 0 not low for an unused compliance code");

  AST_OBSERVE_REM_RCVR: assert property (
    (fsel_q[2:0] == 3'h5 && drive_q[11:9] == 3'h1 && !drive_q[2] && !drive_q[0])
      |=> (led_pin_out[0] == $past(compl_status.rem_rcvr_ok)))
    else $error("pin 0 does not follow remote receiver status");

  AST_OBSERVE_MID_CODES: assert property (
    (fsel_q[2:0] == 3'h5 && drive_q[11:9] inside {3'h2, 3'h3, 3'h4}
      && !drive_q[2] && !drive_q[0])
      |=> (led_pin_out[0] == $past(compl_status[drive_q[11:9]])))
    else $error("pin 0 does not follow the selected status");

  COV_OBSERVE: cover property (fsel_q[2:0] == 3'h5 && drive_q[11:9] == 3'h4);
  COV_FORCE_ALL: cover property (drive_q[8] && drive_q[5] && drive_q[2]);
  COV_READ_BACK: cover property (read && !waitrequest && address == 13'h1148);
  COV_POL_OBSERVE: cover property (fsel_q[2:0] == 3'h5 && drive_q[0]);
  COV_LANE_WRITE: cover property (write && !waitrequest && byteenable == 4'h2);

endmodule // ipo_indicator_override

////////////////////////////////////////////////////////////////////////////
// One indicator pin: force, then polarity, then the output flip-flop.

module ipo_pin_slice (
  input  wire logic ref_clk,
  input  wire logic srst,
  input  wire logic normal_lvl,
  input  wire logic force_en,
  input  wire logic force_val,
  input  wire logic invert,
  output logic      pin_q
);
  import ipo_pkg::*;

  logic pin_d;

  always_comb begin
    // Polarity acts last, so a forced level is inverted as well.
    pin_d = (force_en ? force_val : normal_lvl) ^ invert;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
    end
  end

endmodule // ipo_pin_slice
`default_nettype wire

// *** verilog/ipo_pkg.sv ***
// Purpose: Shared constants and types for the indicator pin override block.
// Assumes: 32-bit Avalon-MM data, byte addresses equal to four times the register index.
// Notes:   Only the low 16 bits of each register are implemented.
`default_nettype none
package ipo_pkg;

  localparam int unsigned ADDR_W    = 13;
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned REG_W     = 16;
  localparam int unsigned NUM_PINS  = 3;

  // Register indices as numbered in the map; the byte address is four times each.
  localparam logic [10:0] IDX_DRIVE_CFG = 11'h451;
  localparam logic [10:0] IDX_FUNC_SEL  = 11'h452;

  localparam logic [15:0] DRIVE_CFG_RST = 16'h0000;
  localparam logic [15:0] FUNC_SEL_RST  = 16'h0000;

  // Writable bits of each register; the rest read as zero.
  localparam logic [15:0] DRIVE_CFG_WMASK = 16'h0fff;
  localparam logic [15:0] FUNC_SEL_WMASK  = 16'h0707;

  // Drive configuration fields.
  localparam int unsigned COMPL_SEL_LSB = 9;
  localparam int unsigned COMPL_SEL_W   = 3;
  localparam int unsigned PIN_FIELD_W   = 3;
  localparam int unsigned POL_OFS       = 0;
  localparam int unsigned VAL_OFS       = 1;
  localparam int unsigned EN_OFS        = 2;

  // Function select fields: pin 0 in bits 2:0, pin 1 in bits 10:8.
  localparam int unsigned FSEL0_LSB = 0;
  localparam int unsigned FSEL1_LSB = 8;
  localparam int unsigned FSEL_W    = 3;
  localparam logic [2:0]  FSEL_OBSERVE = 3'h5;

  typedef enum logic [2:0] {
    IPO_CS_LOC_RCVR  = 3'h0,
    IPO_CS_REM_RCVR  = 3'h1,
    IPO_CS_LOC_SNR   = 3'h2,
    IPO_CS_REM_READY = 3'h3,
    IPO_CS_PMA_WDOG  = 3'h4,
    IPO_CS_LINK_SYNC = 3'h5
  } ipo_compl_sel_e;

  typedef struct packed {
    logic link_sync;
    logic pma_watchdog;
    logic rem_phy_ready;
    logic loc_snr_margin;
    logic rem_rcvr_ok;
    logic loc_rcvr_ok;
  } ipo_compl_s;

  typedef enum logic {
    IPO_BUS_IDLE = 1'b0,
    IPO_BUS_ACK  = 1'b1
  } ipo_bus_e;

endpackage
`default_nettype wire
